// File: logic/fam_pkg.sv
// Constants and types shared by the first flash array map
package fam_pkg;
	localparam int          ADDR_W         = 18;
	localparam int          ARRAY_BYTES    = 32256;
	localparam int          TOP_BYTES      = 128;
	localparam int          ROW_SHIFT      = 6;
	localparam int          PAGE_SHIFT     = 7;
	localparam logic [15:0] ARRAY_FIRST    = 16'h8000;
	localparam logic [15:0] ARRAY_LAST     = 16'hfdff;
	localparam logic [15:0] TOP_PAGE_FIRST = 16'hff80;
	localparam logic [15:0] PROT1_INDEX    = 16'hff80;
	localparam logic [15:0] PROT2_INDEX    = 16'hff81;
	localparam logic [15:0] CTRL_INDEX     = 16'hff88;
	localparam logic [15:0] SECURE_INDEX   = 16'hff89;
	localparam logic [15:0] VECTOR_FIRST   = 16'hffcc;
	localparam logic [15:0] GAP_A_FIRST    = 16'hffcc;
	localparam logic [15:0] GAP_A_LAST     = 16'hffd1;
	localparam logic [15:0] GAP_B_FIRST    = 16'hffd4;
	localparam logic [15:0] GAP_B_LAST     = 16'hffd9;
	localparam logic [7:0]  CTRL_RESET     = 8'h00;
	localparam logic [7:0]  ERASED_BYTE    = 8'hff;
	localparam logic [7:0]  NO_PROTECT     = 8'hff;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_DECERR    = 2'h3;

	typedef struct packed {
		logic [3:0] unused;
		logic       high_voltage_enable;
		logic       mass_select;
		logic       erase_select;
		logic       program_select;
	} fam_ctrl_type;

	typedef struct packed {
		logic        wr;
		logic [15:0] wr_index;
		logic [7:0]  wr_data;
		logic        wr_lane;
		logic        rd;
		logic [15:0] rd_index;
		logic        rd_nonsecure;
	} fam_req_type;

	typedef enum {
		SEQ_IDLE,
		SEQ_SELECTED,
		SEQ_CHECKED,
		SEQ_ARMED,
		SEQ_ACTIVE
	} fam_seq_type;
endpackage

// File: logic/fam_axil_slave.sv
// AXI4-Lite slave front end turning bus transfers into byte requests
`timescale 1ns/1ps
module fam_axil_slave (
	input  wire logic                       clk,
	input  wire logic                       reset,
	input  wire logic [fam_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [fam_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                 s_axi_arprot,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output fam_pkg::fam_req_type            req,
	input  wire logic [7:0]                 rd_data,
	input  wire logic                       rd_ok,
	input  wire logic                       wr_ok
);
	logic        aw_held;
	logic        w_held;
	logic [15:0] aw_index;
	logic [7:0]  w_byte;
	logic        w_lane;

	// No new write is taken until the previous response has left
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		req              = '0;
		req.wr           = aw_held && w_held;
		req.wr_index     = aw_index;
		req.wr_data      = w_byte;
		req.wr_lane      = w_lane;
		req.rd           = s_axi_arvalid && s_axi_arready;
		req.rd_index     = s_axi_araddr[17:2];
		req.rd_nonsecure = s_axi_arprot[1];
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_held  <= 1'b0;
			aw_index <= 16'h0000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held  <= 1'b1;
			aw_index <= s_axi_awaddr[17:2];
		end else if (req.wr) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			w_held <= 1'b0;
			w_byte <= 8'h00;
			w_lane <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_byte <= s_axi_wdata[7:0];
			w_lane <= s_axi_wstrb[0];
		end else if (req.wr) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= fam_pkg::RESP_OKAY;
		end else if (req.wr) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_ok ? fam_pkg::RESP_OKAY : fam_pkg::RESP_DECERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= fam_pkg::RESP_OKAY;
		end else if (req.rd) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_data};
			s_axi_rresp  <= rd_ok ? fam_pkg::RESP_OKAY : fam_pkg::RESP_DECERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// File: logic/fam_flash_array.sv
// First flash array: storage, address map, protection and program/erase control
//
// Contract
// - Array holds exactly 32,256 user bytes
// - Two protect bytes, one per flash block
// - Vector bytes: 40 reduced, 52 full variant
// - Erased bit reads 1, programmed reads 0
// - Page is two rows of 64 bytes
// - Erase covers at least one 128-byte page
// - Programming works on one 64-byte row
// - User array decodes at 8000 to FDFF
// - Protect bytes FF80, FF81; control at FF88
// - Vectors live at FFCC through FFFF
// - Vector high byte even, low byte odd
// - Control register bits start and stop operations
// - Internal charge pump makes the high voltage
// - Security blocks outside viewing of contents
// - High voltage only after select and sequence
// - Program and erase select never both set
// - Protect start is 1, bits[14:7], zeros
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module fam_flash_array #(
	parameter bit FULL_VARIANT = 1'b1
) (
	input  wire logic                       clk,
	input  wire logic                       reset,
	input  wire logic [fam_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [fam_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                 s_axi_arprot,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output logic                            charge_pump_on
);
	fam_pkg::fam_req_type  req;
	fam_pkg::fam_ctrl_type ctrl;
	fam_pkg::fam_ctrl_type wr_ctrl;
	fam_pkg::fam_seq_type  seq;
	fam_pkg::fam_seq_type  next_seq;

	// Nonvolatile cells carry no reset; software erases before use
	logic [7:0]  mem [0:fam_pkg::ARRAY_BYTES-1];
	// The top page starts erased, so an unknown protect byte cannot refuse the first mass erase
	logic [7:0]  top [0:fam_pkg::TOP_BYTES-1] = '{default: fam_pkg::ERASED_BYTE};
	logic        secure_armed;
	logic [15:0] target_index;
	logic        target_protected;
	logic        target_mass;
	logic [7:0]  rd_data;
	logic        rd_ok;
	logic        wr_ok;
	logic [14:0] wr_off;
	logic [14:0] rd_off;
	logic        wr_array;
	logic        wr_top;
	logic        wr_flash;
	logic        rd_array;
	logic        ctrl_wr;
	logic [15:0] prot_start;
	logic        protect_on;
	logic        next_protected;
	logic        hv_allowed;
	logic        hv_grant;
	logic        erase_go;
	logic        prog_wr;

	fam_axil_slave u_slave (
		.clk           (clk),
		.reset         (reset),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arprot  (s_axi_arprot),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.req           (req),
		.rd_data       (rd_data),
		.rd_ok         (rd_ok),
		.wr_ok         (wr_ok)
	);

	function automatic logic is_array(input logic [15:0] i);
		return i >= fam_pkg::ARRAY_FIRST && i <= fam_pkg::ARRAY_LAST;
	endfunction

	// Implemented flash bytes of the top page
	function automatic logic is_top(input logic [15:0] i);
		logic gap;
		gap = (i >= fam_pkg::GAP_A_FIRST && i <= fam_pkg::GAP_A_LAST) ||
			(i >= fam_pkg::GAP_B_FIRST && i <= fam_pkg::GAP_B_LAST);
		return i == fam_pkg::PROT1_INDEX || i == fam_pkg::PROT2_INDEX ||
			(i >= fam_pkg::VECTOR_FIRST && (FULL_VARIANT || !gap));
	endfunction

	function automatic logic in_top_page(input logic [15:0] i);
		return i[15:fam_pkg::PAGE_SHIFT] == fam_pkg::TOP_PAGE_FIRST[15:fam_pkg::PAGE_SHIFT];
	endfunction

	assign wr_ctrl  = fam_pkg::fam_ctrl_type'(req.wr_data);
	assign wr_off   = req.wr_index[14:0];
	assign rd_off   = req.rd_index[14:0];
	assign wr_array = req.wr && req.wr_lane && is_array(req.wr_index);
	assign wr_top   = req.wr && req.wr_lane && is_top(req.wr_index);
	assign wr_flash = wr_array || wr_top;
	assign rd_array = req.rd && is_array(req.rd_index);
	assign ctrl_wr  = req.wr && req.wr_lane && req.wr_index == fam_pkg::CTRL_INDEX;

	assign prot_start = {1'b1, top[0], 7'h00};
	assign protect_on = top[0] != fam_pkg::NO_PROTECT;
	// Any protection at all blocks a mass erase, since it would reach protected bytes
	assign next_protected = ctrl.mass_select ? protect_on :
		(protect_on && req.wr_index >= prot_start);

	// High voltage is granted only from the armed step with the selection unchanged
	assign hv_allowed = seq == fam_pkg::SEQ_ARMED && !target_protected &&
		(ctrl.erase_select || ctrl.program_select) &&
		wr_ctrl.erase_select == ctrl.erase_select &&
		wr_ctrl.program_select == ctrl.program_select;
	assign hv_grant = ctrl_wr && wr_ctrl.high_voltage_enable &&
		!ctrl.high_voltage_enable && hv_allowed;
	assign erase_go = hv_grant && ctrl.erase_select;
	assign prog_wr  = seq == fam_pkg::SEQ_ACTIVE && ctrl.program_select && wr_flash &&
		req.wr_index[15:fam_pkg::ROW_SHIFT] == target_index[15:fam_pkg::ROW_SHIFT];

	assign charge_pump_on = ctrl.high_voltage_enable;

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl <= fam_pkg::CTRL_RESET;
		end else if (ctrl_wr) begin
			// A write asking for both selects leaves the pair as it was
			if (!(wr_ctrl.erase_select && wr_ctrl.program_select)) begin
				ctrl.erase_select   <= wr_ctrl.erase_select;
				ctrl.program_select <= wr_ctrl.program_select;
			end
			ctrl.mass_select         <= wr_ctrl.mass_select;
			ctrl.high_voltage_enable <= wr_ctrl.high_voltage_enable &&
				(ctrl.high_voltage_enable || hv_allowed);
		end
	end

	always_comb begin
		next_seq = seq;
		case (seq)
			fam_pkg::SEQ_IDLE: begin
				if (ctrl.erase_select || ctrl.program_select)
					next_seq = fam_pkg::SEQ_SELECTED;
			end
			fam_pkg::SEQ_SELECTED: begin
				if (req.rd && req.rd_index == fam_pkg::PROT1_INDEX)
					next_seq = fam_pkg::SEQ_CHECKED;
			end
			fam_pkg::SEQ_CHECKED: begin
				if (wr_flash)
					next_seq = fam_pkg::SEQ_ARMED;
			end
			fam_pkg::SEQ_ARMED: begin
				if (hv_grant)
					next_seq = fam_pkg::SEQ_ACTIVE;
			end
			fam_pkg::SEQ_ACTIVE: begin
				if (!ctrl.high_voltage_enable)
					next_seq = fam_pkg::SEQ_IDLE;
			end
			default: next_seq = fam_pkg::SEQ_IDLE;
		endcase
		if (seq != fam_pkg::SEQ_ACTIVE && !ctrl.erase_select && !ctrl.program_select)
			next_seq = fam_pkg::SEQ_IDLE;
	end

	always_ff @(posedge clk) begin
		if (reset)
			seq <= fam_pkg::SEQ_IDLE;
		else
			seq <= next_seq;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			target_index     <= 16'h0000;
			target_protected <= 1'b1;
			target_mass      <= 1'b0;
		end else if (seq == fam_pkg::SEQ_CHECKED && wr_flash) begin
			target_index     <= req.wr_index;
			target_protected <= next_protected;
			target_mass      <= ctrl.mass_select;
		end
	end

	// Programming only clears bits, so new data ANDs into the cell
	always_ff @(posedge clk) begin
		if (erase_go) begin
			for (int i = 0; i < fam_pkg::ARRAY_BYTES; i++) begin
				if (target_mass || i[14:7] == target_index[14:7])
					mem[i] <= fam_pkg::ERASED_BYTE;
			end
		end else if (prog_wr && wr_array) begin
			mem[wr_off] <= mem[wr_off] & req.wr_data;
		end
	end

	// Vectors and protect bytes share the top page and erase with it
	always_ff @(posedge clk) begin
		if (erase_go && (target_mass || in_top_page(target_index))) begin
			for (int i = 0; i < fam_pkg::TOP_BYTES; i++)
				top[i] <= fam_pkg::ERASED_BYTE;
		end else if (prog_wr && wr_top) begin
			top[req.wr_index[6:0]] <= top[req.wr_index[6:0]] & req.wr_data;
		end
	end

	// Once armed, only a reset or a completed mass erase drops security
	always_ff @(posedge clk) begin
		if (reset)
			secure_armed <= 1'b0;
		else if (erase_go && target_mass)
			secure_armed <= 1'b0;
		else if (req.wr && req.wr_lane && req.wr_index == fam_pkg::SECURE_INDEX &&
			req.wr_data[0])
			secure_armed <= 1'b1;
	end

	always_comb begin
		rd_data = 8'h00;
		rd_ok   = 1'b1;
		if (rd_array)
			rd_data = mem[rd_off];
		else if (is_top(req.rd_index))
			rd_data = top[req.rd_index[6:0]];
		else if (req.rd_index == fam_pkg::CTRL_INDEX)
			rd_data = ctrl;
		else if (req.rd_index == fam_pkg::SECURE_INDEX)
			rd_data = {7'h00, secure_armed};
		else if (!in_top_page(req.rd_index))
			rd_ok = 1'b0;
		if ((is_array(req.rd_index) || is_top(req.rd_index)) &&
			secure_armed && req.rd_nonsecure)
			rd_data = 8'h00;
	end

	assign wr_ok = is_array(req.wr_index) || in_top_page(req.wr_index);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	property p_interlock;
		!(ctrl.erase_select && ctrl.program_select);
	endproperty
	a_interlock: assert property (p_interlock)
		else $error("program and erase selects both set");

	property p_hv_grant;
		$rose(ctrl.high_voltage_enable) |->
			$past(seq) == fam_pkg::SEQ_ARMED && !$past(target_protected);
	endproperty
	a_hv_grant: assert property (p_hv_grant)
		else $error("high voltage rose outside an armed unprotected sequence");

	property p_pump_refused;
		ctrl_wr && wr_ctrl.high_voltage_enable && seq == fam_pkg::SEQ_IDLE &&
			!charge_pump_on |=> !charge_pump_on [*2];
	endproperty
	a_pump_refused: assert property (p_pump_refused)
		else $error("charge pump started without a sequence");

	property p_prot_latch;
		seq == fam_pkg::SEQ_CHECKED && wr_flash && !ctrl.mass_select &&
			top[0] != fam_pkg::NO_PROTECT &&
			req.wr_index >= {1'b1, top[0], 7'h00} |=> target_protected;
	endproperty
	a_prot_latch: assert property (p_prot_latch)
		else $error("target inside protected range not flagged");

	property p_idle_write;
		wr_array && seq == fam_pkg::SEQ_IDLE |=>
			mem[$past(wr_off)] == $past(mem[wr_off]);
	endproperty
	a_idle_write: assert property (p_idle_write)
		else $error("array changed by a write outside a sequence");

	property p_page_erase;
		erase_go && !target_mass && is_array(target_index) |=>
			mem[{$past(target_index[14:7]), 7'h00}] == fam_pkg::ERASED_BYTE &&
			mem[{$past(target_index[14:7]), 7'h7f}] == fam_pkg::ERASED_BYTE;
	endproperty
	a_page_erase: assert property (p_page_erase)
		else $error("page erase left bytes unerased");

	property p_row_program;
		prog_wr && wr_array |=>
			mem[$past(wr_off)] == ($past(mem[wr_off]) & $past(req.wr_data));
	endproperty
	a_row_program: assert property (p_row_program)
		else $error("programmed byte does not hold old AND new data");

	property p_other_row;
		seq == fam_pkg::SEQ_ACTIVE && wr_array && !prog_wr |=>
			mem[$past(wr_off)] == $past(mem[wr_off]);
	endproperty
	a_other_row: assert property (p_other_row)
		else $error("byte outside the target row was programmed");

	property p_decode_edge;
		req.rd && req.rd_index == (fam_pkg::ARRAY_LAST + 16'h0001) |=>
			s_axi_rvalid && s_axi_rresp == fam_pkg::RESP_DECERR;
	endproperty
	a_decode_edge: assert property (p_decode_edge)
		else $error("address past the user array was accepted");

	property p_secure_read;
		rd_array && secure_armed && req.rd_nonsecure |=>
			s_axi_rvalid && s_axi_rdata == 32'h0000_0000;
	endproperty
	a_secure_read: assert property (p_secure_read)
		else $error("secured array byte visible to outside read");

	c_erase: cover property (erase_go);
	c_program: cover property (prog_wr ##4 prog_wr);
	c_blocked: cover property (ctrl_wr && wr_ctrl.high_voltage_enable &&
		seq == fam_pkg::SEQ_ARMED && target_protected);
	c_secure: cover property (rd_array && secure_armed && req.rd_nonsecure);
endmodule

// File: tb/fam_cpu_model.sv
// Behavioural on-chip CPU issuing single byte accesses over AXI4-Lite
`timescale 1ns/1ps
module fam_cpu_model (
	input  wire logic                  clk,
	output logic [fam_pkg::ADDR_W-1:0] s_axi_awaddr,
	output logic                       s_axi_awvalid,
	input  wire logic                  s_axi_awready,
	output logic [31:0]                s_axi_wdata,
	output logic [3:0]                 s_axi_wstrb,
	output logic                       s_axi_wvalid,
	input  wire logic                  s_axi_wready,
	input  wire logic [1:0]            s_axi_bresp,
	input  wire logic                  s_axi_bvalid,
	output logic                       s_axi_bready,
	output logic [fam_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic [2:0]                 s_axi_arprot,
	output logic                       s_axi_arvalid,
	input  wire logic                  s_axi_arready,
	input  wire logic [31:0]           s_axi_rdata,
	input  wire logic [1:0]            s_axi_rresp,
	input  wire logic                  s_axi_rvalid,
	output logic                       s_axi_rready
);
	initial begin
		s_axi_awaddr = '0;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = '0;
		s_axi_arprot = 3'h0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
	end

	// Released payload is inverted so a stale value can never pass for a fresh one
	task automatic write(input logic [15:0] index, input logic [7:0] data,
		output logic [1:0] resp);
		@(posedge clk);
		s_axi_awaddr <= {index, 2'b00};
		s_axi_wdata <= {24'h0, data};
		s_axi_wstrb <= 4'h1;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~s_axi_wdata;
			end
			if (s_axi_bvalid) begin
				resp = s_axi_bresp;
				break;
			end
		end
		s_axi_bready <= 1'b0;
	endtask

	task automatic read(input logic [15:0] index, input logic [2:0] prot,
		output logic [7:0] data, output logic [1:0] resp);
		@(posedge clk);
		s_axi_araddr <= {index, 2'b00};
		s_axi_arprot <= prot;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~s_axi_araddr;
			end
			if (s_axi_rvalid) begin
				data = s_axi_rdata[7:0];
				resp = s_axi_rresp;
				break;
			end
		end
		s_axi_rready <= 1'b0;
	endtask
endmodule

// File: tb/tb_flash1_array_map.sv
// Self-checking bench for the first flash array map
`timescale 1ns/1ps
module tb_flash1_array_map;
	localparam logic [15:0] CTRL = fam_pkg::CTRL_INDEX;
	localparam logic [1:0]  OK   = fam_pkg::RESP_OKAY;
	localparam logic [15:0] ERASED_AT [6] = '{16'h8000, 16'hfdff, 16'hff80, 16'hff81,
		16'hffcc, 16'hffff};
	localparam logic [15:0] HOLES [3] = '{16'h7fff, 16'hfe00, 16'hff7f};
	logic                       clk;
	logic                       reset;
	logic [fam_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]                s_axi_wdata, s_axi_rdata;
	logic [3:0]                 s_axi_wstrb;
	logic [2:0]                 s_axi_arprot;
	logic [1:0]                 s_axi_bresp, s_axi_rresp;
	logic                       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                       s_axi_rvalid, s_axi_rready, charge_pump_on;
	logic [7:0]                 img [128];
	int                         fails = 0;
	int                         comparisons = 0;
	int                         cycles = 0;

	fam_flash_array #(.FULL_VARIANT(1'b1)) i_dut (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.charge_pump_on);
	fam_cpu_model i_cpu (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	function automatic logic [15:0] prot_start(input logic [7:0] p);
		return {1'b1, p, 7'h00};
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [15:0] i, input logic [7:0] d);
		logic [1:0] r;
		i_cpu.write(i, d, r);
		check("bresp", r, OK);
	endtask

	task automatic rdc(input logic [15:0] i, input logic [2:0] p, input logic [7:0] e,
		input logic [1:0] er);
		logic [7:0] d;
		logic [1:0] r;
		i_cpu.read(i, p, d, r);
		check("rdata", d, e);
		check("rresp", r, er);
	endtask

	// Select, read the protect byte, latch the target, then raise high voltage
	task automatic arm(input logic [7:0] sel, input logic [15:0] t);
		logic [7:0] d;
		logic [1:0] r;
		wr(CTRL, sel);
		i_cpu.read(fam_pkg::PROT1_INDEX, 3'h0, d, r);
		wr(t, 8'h00);
		wr(CTRL, sel | 8'h08);
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// A full run needs well under this many cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			test_done();
		end
	end

	initial begin
		logic [15:0] a;
		reset = 1'b1;
		void'($urandom(32'h9149));
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		check("pump", charge_pump_on, 1'b0);
		rdc(CTRL, 3'h0, fam_pkg::CTRL_RESET, OK);
		$display("test reset done");
		arm(8'h06, 16'h8000);
		check("pump", charge_pump_on, 1'b1);
		wr(CTRL, 8'h00);
		check("pump", charge_pump_on, 1'b0);
		for (int k = 0; k < 12; k++) begin
			a = (k < 6) ? ERASED_AT[k] : 16'h8000 + 16'($urandom_range(32255));
			rdc(a, 3'h0, fam_pkg::ERASED_BYTE, OK);
		end
		$display("test mass_erase done");
		foreach (img[k])
			img[k] = 8'($urandom());
		arm(8'h01, 16'h8040);
		for (int k = 0; k < 64; k++)
			wr(16'h8040 + 16'(k), img[k]);
		wr(16'h8080, 8'h00);
		wr(CTRL, 8'h00);
		rdc(16'h8080, 3'h0, 8'hff, OK);
		arm(8'h01, 16'h8080);
		for (int k = 0; k < 64; k++)
			wr(16'h8080 + 16'(k), img[64 + k]);
		wr(CTRL, 8'h00);
		for (int k = 0; k < 128; k++)
			rdc(16'h8040 + 16'(k), 3'h0, img[k], OK);
		arm(8'h01, 16'hffcc);
		wr(16'hffcc, 8'h12);
		wr(16'hfffe, 8'hc3);
		wr(16'hffff, 8'h5a);
		wr(CTRL, 8'h00);
		rdc(16'hffcc, 3'h0, 8'h12, OK);
		rdc(16'hfffe, 3'h0, 8'hc3, OK);
		rdc(16'hffff, 3'h0, 8'h5a, OK);
		wr(16'h8040, 8'h00);
		rdc(16'h8040, 3'h0, img[0], OK);
		$display("test program done");
		arm(8'h02, 16'h8090);
		wr(CTRL, 8'h00);
		rdc(16'h8080, 3'h0, 8'hff, OK);
		rdc(16'h80bf, 3'h0, 8'hff, OK);
		rdc(16'h807f, 3'h0, img[63], OK);
		$display("test page_erase done");
		wr(CTRL, 8'h08);
		check("pump", charge_pump_on, 1'b0);
		wr(CTRL, 8'h01);
		wr(CTRL, 8'h03);
		rdc(CTRL, 3'h0, 8'h01, OK);
		wr(CTRL, 8'h09);
		check("pump", charge_pump_on, 1'b0);
		rdc(CTRL, 3'h0, 8'h01, OK);
		wr(CTRL, 8'h00);
		$display("test interlock done");
		arm(8'h01, 16'hff80);
		wr(16'hff80, 8'hfe);
		wr(CTRL, 8'h00);
		rdc(16'hff80, 3'h0, 8'hfe, OK);
		for (int k = 0; k < 2; k++) begin
			a = (k == 0) ? 16'h8100 : 16'hffcc;
			arm(8'h02, a);
			check("pump", charge_pump_on, a < prot_start(8'hfe));
			wr(CTRL, 8'h00);
		end
		rdc(16'hfffe, 3'h0, 8'hc3, OK);
		$display("test protect done");
		foreach (HOLES[k])
			rdc(HOLES[k], 3'h0, 8'h00, fam_pkg::RESP_DECERR);
		$display("test decode done");
		wr(fam_pkg::SECURE_INDEX, 8'h01);
		rdc(16'h8040, 3'h2, 8'h00, OK);
		rdc(16'h8040, 3'h0, img[0], OK);
		$display("test security done");
		test_done();
	end
endmodule
